// file: verilog/ppc_pkg.sv
package ppc_pkg;

    // ----------------------------------------------------------------
    // Bus and port geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int PORT_W    = 16;
    localparam int NUM_PORTS = 3;
    localparam int PINS_A    = 16;
    localparam int PINS_B    = 16;
    localparam int PINS_C    = 15;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PORT_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] PORT_STRIDE   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PORT_END  = 8'h40;

    // Word index inside one port block
    localparam logic [1:0] KIND_IE    = 2'h0;
    localparam logic [1:0] KIND_OE    = 2'h1;
    localparam logic [1:0] KIND_CARD  = 2'h2;
    localparam logic [1:0] KIND_PDSEL = 2'h3;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_CFG_BIT   = 0;
    localparam int CTRL_RUN_BIT   = 1;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_HW_BIT    = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic              RST_CFG  = 1'b0;
    localparam logic              RST_RUN  = 1'b0;
    localparam logic [PORT_W-1:0] RST_PORT = 16'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_BOOT = 3'b010,
        ST_RUN  = 3'b100
    } ppc_state_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } ppc_apb_req_s;

    typedef struct packed {
        logic ie;
        logic oe;
        logic card;
        logic pdsel;
    } ppc_pin_ctl_s;

    typedef struct packed {
        logic pull_up;
        logic pull_down;
        logic drive_en;
    } ppc_term_s;

endpackage

// file: verilog/ppc_pin_cell.sv
`timescale 1ns/1ns
module ppc_pin_cell (
    // Phase and global setting
    input  wire ppc_pkg::ppc_state_e   state_i,
    input  wire logic                  cfg_i,
    // Per-pin controls
    input  wire ppc_pkg::ppc_pin_ctl_s ctl_i,
    // Termination request
    output      ppc_pkg::ppc_term_s    term_o
);

    // ----------------------------------------------------------------
    // Termination decode
    // ----------------------------------------------------------------
    wire logic in_hold  = (state_i == ppc_pkg::ST_HOLD);
    wire logic in_boot  = (state_i == ppc_pkg::ST_BOOT);
    wire logic in_run   = (state_i == ppc_pkg::ST_RUN);
    wire logic pu_cfg0  = ~ctl_i.ie & ~ctl_i.oe;
    wire logic pu_cfg1  = ~ctl_i.oe;
    wire logic pu_base  = cfg_i ? pu_cfg1 : pu_cfg0;
    // Pull-down pins give up the pull-up entirely, so both never fight
    wire logic pu_run   = pu_base & ~ctl_i.card & ~ctl_i.pdsel;
    wire logic pd_run   = ctl_i.pdsel & ~ctl_i.oe;

    assign term_o.pull_up   = ~in_hold & (in_boot | (in_run & pu_run));
    assign term_o.pull_down = in_run & pd_run;
    assign term_o.drive_en  = in_run & ctl_i.oe;

endmodule

// file: verilog/ppc_top.sv
`timescale 1ns/1ns
// How it works
// - While the hardware reset pin is low every port pad is three-stated, no drive and no pull.
// - After that pin is released and before code runs, every port pad gets its pull-up.
// - Once code runs, each pad follows its software-set input-enable and output-enable.
// - With global pull configuration 0 a pull-up is on only when input and output enable are off.
// - With global pull configuration 1 a pull-up is on whenever the output enable, card mode and pull-down select of the pin are off.
// - Once code runs, a pin in card interface mode never has its pull-up on.
// - Memory strobe, ready and slave-select pins get a pull-down while their output enable is off.
module ppc_top #(
    parameter int PINS_A = ppc_pkg::PINS_A,
    parameter int PINS_B = ppc_pkg::PINS_B,
    parameter int PINS_C = ppc_pkg::PINS_C,
    parameter int NPINS  = PINS_A + PINS_B + PINS_C
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    // Hardware reset pin
    input  wire logic                        hardware_reset_n_i,
    // APB slave
    input  wire ppc_pkg::ppc_apb_req_s       apb_req_i,
    output      logic                        pready_o,
    output      logic [ppc_pkg::DATA_W-1:0]  prdata_o,
    output      logic                        pslverr_o,
    // Pad controls
    output      logic [NPINS-1:0]            pull_up_o,
    output      logic [NPINS-1:0]            pull_down_o,
    output      logic [NPINS-1:0]            drive_en_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [ppc_pkg::PORT_W-1:0] port_mask(input logic [1:0] idx);
        int n;
        n = (idx == 2'd0) ? PINS_A : (idx == 2'd1) ? PINS_B : PINS_C;
        port_mask = ppc_pkg::PORT_W'((33'd1 << n) - 33'd1);
    endfunction

    // ----------------------------------------------------------------
    // Hardware reset pin synchroniser
    // ----------------------------------------------------------------
    logic hw_s1;
    logic hw_s2;
    logic hw_s3;
    logic hw_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_s1 <= 1'b0;
            hw_s2 <= 1'b0;
            hw_s3 <= 1'b0;
            hw_q  <= 1'b0;
        end else begin
            hw_s1 <= hardware_reset_n_i;
            hw_s2 <= hw_s1;
            hw_s3 <= hw_s2;
            if (hw_s2 == hw_s3) begin
                hw_q <= hw_s3;
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase machine
    // ----------------------------------------------------------------
    ppc_pkg::ppc_state_e state;
    ppc_pkg::ppc_state_e next_state;
    logic                run_req;
    logic                cfg;

    always_comb begin
        next_state = state;
        unique case (state)
            ppc_pkg::ST_HOLD: begin
                if (hw_q) begin
                    next_state = ppc_pkg::ST_BOOT;
                end
            end
            ppc_pkg::ST_BOOT: begin
                if (!hw_q) begin
                    next_state = ppc_pkg::ST_HOLD;
                end else if (run_req) begin
                    next_state = ppc_pkg::ST_RUN;
                end
            end
            ppc_pkg::ST_RUN: begin
                if (!hw_q) begin
                    next_state = ppc_pkg::ST_HOLD;
                end
            end
            default: begin
                next_state = ppc_pkg::ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ppc_pkg::ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire logic [ppc_pkg::ADDR_W-1:0] addr      = apb_req_i.paddr;
    wire logic                       setup     = apb_req_i.psel & ~apb_req_i.penable;
    wire logic                       access    = apb_req_i.psel & apb_req_i.penable & pready_o;
    wire logic                       is_ctrl   = (addr == ppc_pkg::OFF_CTRL);
    wire logic                       is_status = (addr == ppc_pkg::OFF_STATUS);
    wire logic                       is_port   = (addr >= ppc_pkg::OFF_PORT_BASE)
                                               & (addr < ppc_pkg::OFF_PORT_END)
                                               & (addr[1:0] == 2'b00);
    wire logic [1:0]                 port_idx  = addr[5:4] - 2'd1;
    wire logic [1:0]                 kind      = addr[3:2];
    wire logic                       mapped    = is_ctrl | is_status | is_port;
    // Writes are ignored while the pads are held in hardware reset
    wire logic                       wr_en     = access & apb_req_i.pwrite
                                               & (state != ppc_pkg::ST_HOLD);
    wire logic [ppc_pkg::PORT_W-1:0] wr_word   = apb_req_i.pwdata[ppc_pkg::PORT_W-1:0]
                                               & port_mask(port_idx);

    // ----------------------------------------------------------------
    // Control and per-port registers
    // ----------------------------------------------------------------
    logic [ppc_pkg::PORT_W-1:0] ie_r    [ppc_pkg::NUM_PORTS];
    logic [ppc_pkg::PORT_W-1:0] oe_r    [ppc_pkg::NUM_PORTS];
    logic [ppc_pkg::PORT_W-1:0] card_r  [ppc_pkg::NUM_PORTS];
    logic [ppc_pkg::PORT_W-1:0] pdsel_r [ppc_pkg::NUM_PORTS];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg     <= ppc_pkg::RST_CFG;
            run_req <= ppc_pkg::RST_RUN;
        end else if (state == ppc_pkg::ST_HOLD) begin
            cfg     <= ppc_pkg::RST_CFG;
            run_req <= ppc_pkg::RST_RUN;
        end else if (wr_en && is_ctrl) begin
            cfg     <= apb_req_i.pwdata[ppc_pkg::CTRL_CFG_BIT];
            // Start of code execution cannot be undone short of a pin reset
            run_req <= run_req | apb_req_i.pwdata[ppc_pkg::CTRL_RUN_BIT];
        end
    end

    generate
        for (genvar p = 0; p < ppc_pkg::NUM_PORTS; p++) begin : g_port
            wire logic hit = wr_en & is_port & (port_idx == 2'(p));
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ie_r[p]    <= ppc_pkg::RST_PORT;
                    oe_r[p]    <= ppc_pkg::RST_PORT;
                    card_r[p]  <= ppc_pkg::RST_PORT;
                    pdsel_r[p] <= ppc_pkg::RST_PORT;
                end else if (state == ppc_pkg::ST_HOLD) begin
                    ie_r[p]    <= ppc_pkg::RST_PORT;
                    oe_r[p]    <= ppc_pkg::RST_PORT;
                    card_r[p]  <= ppc_pkg::RST_PORT;
                    pdsel_r[p] <= ppc_pkg::RST_PORT;
                end else if (hit) begin
                    ie_r[p]    <= (kind == ppc_pkg::KIND_IE)    ? wr_word : ie_r[p];
                    oe_r[p]    <= (kind == ppc_pkg::KIND_OE)    ? wr_word : oe_r[p];
                    card_r[p]  <= (kind == ppc_pkg::KIND_CARD)  ? wr_word : card_r[p];
                    pdsel_r[p] <= (kind == ppc_pkg::KIND_PDSEL) ? wr_word : pdsel_r[p];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path, answered in the first access cycle
    // ----------------------------------------------------------------
    wire logic [ppc_pkg::PORT_W-1:0] port_word =
        (kind == ppc_pkg::KIND_IE)   ? ie_r[port_idx]   :
        (kind == ppc_pkg::KIND_OE)   ? oe_r[port_idx]   :
        (kind == ppc_pkg::KIND_CARD) ? card_r[port_idx] : pdsel_r[port_idx];
    wire logic [ppc_pkg::DATA_W-1:0] ctrl_word   =
        ppc_pkg::DATA_W'({run_req, cfg});
    wire logic [ppc_pkg::DATA_W-1:0] status_word =
        ppc_pkg::DATA_W'({hw_q, state});
    wire logic [ppc_pkg::DATA_W-1:0] rd_word     =
        is_ctrl   ? ctrl_word   :
        is_status ? status_word :
        is_port   ? ppc_pkg::DATA_W'(port_word) : '0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup;
            prdata_o  <= (setup && !apb_req_i.pwrite) ? rd_word : '0;
            pslverr_o <= setup & ~mapped;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin termination
    // ----------------------------------------------------------------
    wire logic [NPINS-1:0] ie_f    = {ie_r[2][PINS_C-1:0], ie_r[1][PINS_B-1:0],
                                      ie_r[0][PINS_A-1:0]};
    wire logic [NPINS-1:0] oe_f    = {oe_r[2][PINS_C-1:0], oe_r[1][PINS_B-1:0],
                                      oe_r[0][PINS_A-1:0]};
    wire logic [NPINS-1:0] card_f  = {card_r[2][PINS_C-1:0], card_r[1][PINS_B-1:0],
                                      card_r[0][PINS_A-1:0]};
    wire logic [NPINS-1:0] pdsel_f = {pdsel_r[2][PINS_C-1:0], pdsel_r[1][PINS_B-1:0],
                                      pdsel_r[0][PINS_A-1:0]};
    logic [NPINS-1:0] next_pu;
    logic [NPINS-1:0] next_pd;
    logic [NPINS-1:0] next_drv;

    generate
        for (genvar i = 0; i < NPINS; i++) begin : g_pin
            ppc_pkg::ppc_term_s    term;
            ppc_pkg::ppc_pin_ctl_s ctl;
            assign ctl = '{ie: ie_f[i], oe: oe_f[i], card: card_f[i], pdsel: pdsel_f[i]};
            ppc_pin_cell u_cell (
                .state_i (state),
                .cfg_i   (cfg),
                .ctl_i   (ctl),
                .term_o  (term)
            );
            assign next_pu[i]  = term.pull_up;
            assign next_pd[i]  = term.pull_down;
            assign next_drv[i] = term.drive_en;
        end
    endgenerate

    // Outputs lag the phase by one cycle so every pad line is a clean flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pull_up_o   <= '0;
            pull_down_o <= '0;
            drive_en_o  <= '0;
        end else begin
            pull_up_o   <= next_pu;
            pull_down_o <= next_pd;
            drive_en_o  <= next_drv;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wire logic in_run = (state == ppc_pkg::ST_RUN);

    a_hold_tristate: assert property ((state == ppc_pkg::ST_HOLD) |=>
        (pull_up_o == '0) && (pull_down_o == '0) && (drive_en_o == '0))
        else $error("pads not three-state in hold");
    a_pin_low_hold: assert property ($fell(hw_q) |=> ##1
        (drive_en_o == '0) && (pull_up_o == '0))
        else $error("pin reset did not three-state pads");
    a_boot_pullup: assert property ((state == ppc_pkg::ST_BOOT) |=>
        (pull_up_o == '1) && (drive_en_o == '0) && (pull_down_o == '0))
        else $error("boot phase pull-ups missing");
    a_run_follow_oe: assert property (in_run |=> drive_en_o == $past(oe_f))
        else $error("drive does not follow output enable");
    a_cfg0_pullup: assert property ((in_run && !cfg) |=>
        pull_up_o == $past(~ie_f & ~oe_f & ~card_f & ~pdsel_f))
        else $error("config 0 pull-up wrong");
    a_cfg1_pullup: assert property ((in_run && cfg) |=>
        pull_up_o == $past(~oe_f & ~card_f & ~pdsel_f))
        else $error("config 1 pull-up wrong");
    a_card_no_pull: assert property (in_run |=> (pull_up_o & $past(card_f)) == '0)
        else $error("pull-up on card interface pin");
    a_pd_follow_oe: assert property (in_run |=> pull_down_o == $past(pdsel_f & ~oe_f))
        else $error("pull-down does not follow output enable");
    a_no_both_pulls: assert property ((pull_up_o & pull_down_o) == '0)
        else $error("pull-up and pull-down both on");
    a_apb_one_wait: assert property (setup |=> pready_o ##1 !pready_o)
        else $error("ready not a single cycle after setup");

    // Slave error follows the map and read data is zero outside a read; a dropped pin must also drop the phase and the control word, not only the pads
    a_slverr_map: assert property (setup |=> pslverr_o == $past(~mapped))
        else $error("slave error does not match the address map");
    a_rdata_idle: assert property (!(setup && !apb_req_i.pwrite) |=> prdata_o == '0)
        else $error("read data not zero outside a read");
    a_hold_clears: assert property ((state == ppc_pkg::ST_HOLD) |=>
        (cfg == ppc_pkg::RST_CFG) && (run_req == ppc_pkg::RST_RUN))
        else $error("control kept while pads held");
    a_pin_drop_run: assert property ((in_run && !hw_q) |=>
        (state == ppc_pkg::ST_HOLD))
        else $error("run phase survived a pin reset");

    c_boot_to_run: cover property ((state == ppc_pkg::ST_BOOT) ##1 in_run);
    c_cfg1_run: cover property (in_run && cfg && (oe_f != '0));
    c_port_write: cover property (wr_en && is_port);
    c_pin_reset_run: cover property (in_run ##1 !hw_q);
    c_bad_addr: cover property (setup && !mapped);

endmodule

// file: bench/ppc_board.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Board side of the port pads
// ----------------------------------------------------------------
module ppc_board (
    // Clock
    input  wire logic        clk_i,
    // Pad controls from the device
    input  wire logic [46:0] pull_up_i,
    input  wire logic [46:0] pull_down_i,
    input  wire logic [46:0] drive_en_i,
    // Pad levels seen on the board
    output      logic [46:0] level_o
);
    initial level_o = '0;
    // A floating or driven pad toggles, since its real level is unknown here
    always @(posedge clk_i) begin
        for (int i = 0; i < 47; i++) begin
            if (pull_up_i[i] && !drive_en_i[i]) begin
                level_o[i] <= 1'b1;
            end else if (pull_down_i[i] && !drive_en_i[i]) begin
                level_o[i] <= 1'b0;
            end else begin
                level_o[i] <= ~level_o[i];
            end
        end
    end
endmodule

// file: bench/port_pad_pull_control_tb.sv
`timescale 1ns/1ns
module port_pad_pull_control_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                  clk_i   = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic                  hw_n    = 1'b1;
    ppc_pkg::ppc_apb_req_s req     = '0;
    logic                  pready_o;
    logic [31:0]           prdata_o;
    logic                  pslverr_o;
    logic [46:0]           pu;
    logic [46:0]           pdn;
    logic [46:0]           de;
    logic [46:0]           lvl;
    logic [46:0]           ie, oe, cd, ps;
    logic                  cfg = 1'b0;
    logic [31:0]           rd;
    logic                  err;
    int                    fails  = 0;
    int                    checks = 0;

    always #5 clk_i = ~clk_i;

    ppc_top ppc_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .hardware_reset_n_i(hw_n),
        .apb_req_i(req), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .pull_up_o(pu), .pull_down_o(pdn), .drive_en_o(de)
    );
    ppc_board ppc_board_i (
        .clk_i(clk_i), .pull_up_i(pu), .pull_down_i(pdn), .drive_en_i(de), .level_o(lvl)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [46:0] got, input logic [46:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // One APB transfer; held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            close_out();
        end
        rd = prdata_o;
        err = pslverr_o;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        xfer(1'b0, a, 32'h0);
        chk({15'h0, rd}, {15'h0, exp}, "read data");
        chk({46'h0, err}, {46'h0, e}, "slave error");
    endtask

    task automatic wport(input logic [1:0] k, input logic [46:0] v);
        logic [47:0] x;
        x = {1'b0, v};
        for (int p = 0; p < 3; p++) begin
            xfer(1'b1, ppc_pkg::OFF_PORT_BASE + ppc_pkg::PORT_STRIDE * 8'(p)
                 + {4'h0, k, 2'b00}, {16'h0, x[16*p +: 16]});
        end
    endtask

    function automatic logic [46:0] epu();
        logic [46:0] r;
        for (int i = 0; i < 47; i++) begin
            r[i] = !ps[i] && !cd[i] && !oe[i] && (cfg || !ie[i]);
        end
        return r;
    endfunction

    // Expected pads worked out from the settings held in the bench
    task automatic padchk();
        repeat (2) @(posedge clk_i);
        chk(pu, epu(), "pull-up");
        chk(pdn, ps & ~oe, "pull-down");
        chk(de, oe, "drive enable");
        chk(lvl & (epu() | (ps & ~oe)), epu(), "board level");
    endtask

    task automatic hold_chk();
        repeat (8) @(posedge clk_i);
        chk(pu | pdn | de, 47'h0, "pads not three-stated");
    endtask

    task automatic boot_chk();
        repeat (8) @(posedge clk_i);
        chk(pu, {47{1'b1}}, "boot pull-up");
        chk(pdn | de, 47'h0, "boot drive");
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        #100us;
        fails++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 47; i++) begin
            ie[i] = i[0];
            oe[i] = i[1];
            cd[i] = i[2];
            ps[i] = i[3];
        end
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        boot_chk();
        chk(lvl, {47{1'b1}}, "boot level");
        rchk(ppc_pkg::OFF_STATUS, {28'h0, 1'b1, ppc_pkg::ST_BOOT}, 1'b0);
        wport(ppc_pkg::KIND_IE, ie);
        wport(ppc_pkg::KIND_OE, oe);
        wport(ppc_pkg::KIND_CARD, cd);
        wport(ppc_pkg::KIND_PDSEL, ps);
        boot_chk();
        xfer(1'b1, ppc_pkg::OFF_CTRL, 32'h2);
        rchk(ppc_pkg::OFF_STATUS, {28'h0, 1'b1, ppc_pkg::ST_RUN}, 1'b0);
        padchk();
        cfg = 1'b1;
        xfer(1'b1, ppc_pkg::OFF_CTRL, 32'h3);
        padchk();
        rchk(8'h30, {17'h0, ie[46:32]}, 1'b0);
        rchk(8'h08, 32'h0, 1'b1);
        rchk(8'h11, 32'h0, 1'b1);
        xfer(1'b1, ppc_pkg::OFF_STATUS, 32'h0);
        chk({46'h0, err}, 47'h0, "status write");
        rchk(ppc_pkg::OFF_STATUS, {28'h0, 1'b1, ppc_pkg::ST_RUN}, 1'b0);
        hw_n <= 1'b0;
        hold_chk();
        rchk(ppc_pkg::OFF_STATUS, {28'h0, 1'b0, ppc_pkg::ST_HOLD}, 1'b0);
        xfer(1'b1, ppc_pkg::OFF_CTRL, 32'h3);
        rchk(ppc_pkg::OFF_CTRL, 32'h0, 1'b0);
        rchk(8'h14, 32'h0, 1'b0);
        hold_chk();
        hw_n <= 1'b1;
        boot_chk();
        close_out();
    end
endmodule
